// ### hw/sec_pkg.sv
// Shared constants and types of the serial EEPROM command slave.
// Assumes a 100 MHz system clock and a 12-bit word address space.
package sec_pkg;

  // Control byte layout and matching
  localparam logic [3:0]  CTRL_CODE        = 4'ha;
  localparam int          RW_BIT           = 0;

  // Array and page geometry
  localparam int          ADDR_W           = 12;
  localparam int          PAGE_BITS        = 5;
  localparam int          PAGE_BYTES       = 32;
  localparam int          MEM_BYTES        = 4096;
  localparam logic [11:0] TOP_WORD_ADDRESS = 12'hfff;
  localparam logic [11:0] PTR_RESET        = 12'h000;
  localparam logic [4:0]  PAGE_LAST        = 5'h1f;

  // Positions in the nine-clock byte frame, counted in rising SCL edges
  localparam logic [3:0]  BIT_ACK          = 4'h8;
  localparam logic [3:0]  BIT_DONE         = 4'h9;
  localparam logic [3:0]  BIT_LAST_DATA    = 4'h7;
  localparam logic [3:0]  BIT_FIRST        = 4'h1;

  // Self-timed write cycle
  localparam int          CLK_FREQ_HZ      = 100_000_000;
  localparam int          WC_TIME_MS       = 5;
  localparam int          WC_CYCLES        = WC_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int          WC_MARGIN        = 16;

  typedef enum logic [2:0] {
    SEC_IDLE,
    SEC_CTRL,
    SEC_ADDR_HI,
    SEC_ADDR_LO,
    SEC_WDATA,
    SEC_RDATA
  } sec_state_t;

endpackage : sec_pkg

// ### hw/sec_eeprom_slave.sv
// Two-wire serial EEPROM command slave: control byte, address, page buffer,
// self-timed write cycle and current, random and sequential reads.
// Assumes LINK_CLK is a free-running sampling clock far faster than SCL,
// and that the SDA wire level is resolved outside from SDA_OE.
`timescale 1ns/1ps
`default_nettype none

module sec_eeprom_slave #(
  parameter int WC_CYCLES = sec_pkg::WC_CYCLES
) (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic LINK_CLK,
  input  wire logic SCL,
  input  wire logic SDA_I,
  output logic      SDA_O,
  output logic      SDA_OE,
  input  wire logic WP,
  input  wire logic CHIP_SELECT_BIT0,
  input  wire logic CHIP_SELECT_BIT1,
  input  wire logic CHIP_SELECT_BIT2
);
  localparam int CNT_W = $clog2(WC_CYCLES + 1);
  logic             lrst_meta;
  logic             link_rst;
  logic             scl_meta;
  logic             scl_s;
  logic             scl_d;
  logic             sda_meta;
  logic             sda_s;
  logic             sda_d;
  logic             wp_meta;
  logic             wp_s;
  logic [2:0]       cs_meta;
  logic [2:0]       cs_s;
  logic             done_meta;
  logic             done_s;
  logic             done_tog_reg;

  always_ff @(posedge LINK_CLK) begin
    lrst_meta <= RST;
    link_rst  <= lrst_meta;
    scl_meta  <= SCL;
    scl_s     <= scl_meta;
    scl_d     <= scl_s;
    sda_meta  <= SDA_I;
    sda_s     <= sda_meta;
    sda_d     <= sda_s;
    wp_meta   <= WP;
    wp_s      <= wp_meta;
    cs_meta   <= {CHIP_SELECT_BIT2, CHIP_SELECT_BIT1, CHIP_SELECT_BIT0};
    cs_s      <= cs_meta;
    done_meta <= done_tog_reg;
    done_s    <= done_meta;
  end
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  // Conditions are only seen while SCL is high, so data moves with SCL low
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  sec_pkg::sec_state_t st_reg;
  sec_pkg::sec_state_t st_next;
  logic [3:0]          bit_reg;
  logic [3:0]          bit_next;
  logic [7:0]          sh_reg;
  logic [7:0]          sh_next;
  logic [7:0]          rd_reg;
  logic [7:0]          rd_next;
  logic [11:0]         ptr_reg;
  logic [11:0]         ptr_next;
  logic [3:0]          hi_reg;
  logic [3:0]          hi_next;
  logic                drv_reg;
  logic                drv_next;
  logic                wr_pend_reg;
  logic                wr_pend_next;
  logic                commit_reg;
  logic                commit_next;
  logic [4:0]          ccnt_reg;
  logic [4:0]          ccnt_next;
  logic [6:0]          cpage_reg;
  logic [6:0]          cpage_next;
  logic                wc_req_reg;
  logic                wc_req_next;
  logic [31:0]         valid_reg;
  logic [31:0]         valid_next;
  logic [7:0]          mem [0:sec_pkg::MEM_BYTES-1];
  logic [7:0]          pbuf [0:sec_pkg::PAGE_BYTES-1];
  logic                buf_we;
  logic [4:0]          buf_idx;
  logic [7:0]          buf_wd;
  logic                mem_we;
  logic [11:0]         mem_wa;
  logic [7:0]          mem_wd;
  logic                busy;
  logic                ctrl_match;
  logic [11:0]         ptr_inc;
  // Busy spans the commit burst and the timed cycle in the system domain
  assign busy       = commit_reg | (wc_req_reg != done_s);
  assign ctrl_match = (sh_reg[7:4] == sec_pkg::CTRL_CODE) && (sh_reg[3:1] == cs_s);
  assign ptr_inc    = ptr_reg + 12'h001;
  always_comb begin
    st_next      = st_reg;
    bit_next     = bit_reg;
    sh_next      = sh_reg;
    rd_next      = rd_reg;
    ptr_next     = ptr_reg;
    hi_next      = hi_reg;
    drv_next     = drv_reg;
    wr_pend_next = wr_pend_reg;
    commit_next  = commit_reg;
    ccnt_next    = ccnt_reg;
    cpage_next   = cpage_reg;
    wc_req_next  = wc_req_reg;
    valid_next   = valid_reg;
    buf_we       = 1'b0;
    buf_idx      = ptr_reg[4:0];
    buf_wd       = sh_reg;
    mem_we       = 1'b0;
    mem_wa       = {cpage_reg, ccnt_reg};
    mem_wd       = pbuf[ccnt_reg];

    // Commit burst: one buffered byte per link clock into its page
    if (commit_reg) begin
      mem_we    = valid_reg[ccnt_reg];
      ccnt_next = ccnt_reg + 5'h01;
      if (ccnt_reg == sec_pkg::PAGE_LAST) begin
        commit_next = 1'b0;
        valid_next  = '0;
      end
    end

    if (start_det) begin
      // A repeated START aborts a pending write; the pointer stays loaded
      st_next  = sec_pkg::SEC_CTRL;
      bit_next = 4'h0;
      drv_next = 1'b0;
      if (wr_pend_reg) begin
        wr_pend_next = 1'b0;
        valid_next   = '0;
      end
    end else if (stop_det) begin
      st_next  = sec_pkg::SEC_IDLE;
      bit_next = 4'h0;
      drv_next = 1'b0;
      if (wr_pend_reg) begin
        wr_pend_next = 1'b0;
        if (wp_s) begin
          valid_next = '0;
        end else begin
          commit_next = 1'b1;
          ccnt_next   = 5'h00;
          cpage_next  = ptr_reg[11:5];
          wc_req_next = ~wc_req_reg;
        end
      end
    end else if (st_reg != sec_pkg::SEC_IDLE) begin
      if (scl_rise) begin
        if (bit_reg < sec_pkg::BIT_ACK) begin
          sh_next = {sh_reg[6:0], sda_s};
        end
        bit_next = bit_reg + 4'h1;
        if (st_reg == sec_pkg::SEC_RDATA && bit_reg == sec_pkg::BIT_ACK) begin
          ptr_next = ptr_inc;
          if (sda_s) begin
            st_next  = sec_pkg::SEC_IDLE;
            drv_next = 1'b0;
          end else begin
            rd_next = mem[ptr_inc];
          end
        end
      end else if (scl_fall) begin
        if (bit_reg == sec_pkg::BIT_ACK && st_reg != sec_pkg::SEC_RDATA) begin
          drv_next = 1'b1;
          unique case (st_reg)
            sec_pkg::SEC_CTRL: begin
              if (ctrl_match && !busy) begin
                if (sh_reg[sec_pkg::RW_BIT]) begin
                  // Stay here through the ack slot so it is not taken as a master ack
                  rd_next = mem[ptr_reg];
                end else begin
                  st_next = sec_pkg::SEC_ADDR_HI;
                end
              end else begin
                st_next  = sec_pkg::SEC_IDLE;
                drv_next = 1'b0;
              end
            end
            sec_pkg::SEC_ADDR_HI: begin
              hi_next = sh_reg[3:0];
              st_next = sec_pkg::SEC_ADDR_LO;
            end
            sec_pkg::SEC_ADDR_LO: begin
              ptr_next = {hi_reg, sh_reg};
              st_next  = sec_pkg::SEC_WDATA;
            end
            sec_pkg::SEC_WDATA: begin
              buf_we             = 1'b1;
              valid_next[buf_idx] = 1'b1;
              wr_pend_next       = 1'b1;
              ptr_next           = {ptr_reg[11:5], ptr_reg[4:0] + 5'h01};
            end
            default: begin
              st_next  = sec_pkg::SEC_IDLE;
              drv_next = 1'b0;
            end
          endcase
        end else if (bit_reg == sec_pkg::BIT_DONE) begin
          bit_next = 4'h0;
          drv_next = 1'b0;
          if (st_reg == sec_pkg::SEC_RDATA || st_reg == sec_pkg::SEC_CTRL) begin
            st_next  = sec_pkg::SEC_RDATA;
            drv_next = ~rd_reg[7];
          end
        end else if (st_reg == sec_pkg::SEC_RDATA) begin
          if (bit_reg >= sec_pkg::BIT_FIRST && bit_reg <= sec_pkg::BIT_LAST_DATA) begin
            rd_next  = {rd_reg[6:0], 1'b0};
            drv_next = ~rd_reg[6];
          end else if (bit_reg == sec_pkg::BIT_ACK) begin
            drv_next = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      st_reg      <= sec_pkg::SEC_IDLE;
      bit_reg     <= 4'h0;
      sh_reg      <= 8'h00;
      rd_reg      <= 8'h00;
      ptr_reg     <= sec_pkg::PTR_RESET;
      hi_reg      <= 4'h0;
      drv_reg     <= 1'b0;
      wr_pend_reg <= 1'b0;
      commit_reg  <= 1'b0;
      ccnt_reg    <= 5'h00;
      cpage_reg   <= 7'h00;
      wc_req_reg  <= 1'b0;
      valid_reg   <= 32'h0000_0000;
    end else begin
      st_reg      <= st_next;
      bit_reg     <= bit_next;
      sh_reg      <= sh_next;
      rd_reg      <= rd_next;
      ptr_reg     <= ptr_next;
      hi_reg      <= hi_next;
      drv_reg     <= drv_next;
      wr_pend_reg <= wr_pend_next;
      commit_reg  <= commit_next;
      ccnt_reg    <= ccnt_next;
      cpage_reg   <= cpage_next;
      wc_req_reg  <= wc_req_next;
      valid_reg   <= valid_next;
    end
  end

  // Array and page buffer contents are not reset
  always_ff @(posedge LINK_CLK) begin
    if (buf_we) begin
      pbuf[buf_idx] <= buf_wd;
    end
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign SDA_O  = 1'b0;
  assign SDA_OE = drv_reg;
  logic             req_meta;
  logic             req_s;
  logic             req_d;
  logic             wc_run_reg;
  logic             wc_run_next;
  logic [CNT_W-1:0] wc_cnt_reg;
  logic [CNT_W-1:0] wc_cnt_next;
  logic             done_tog_next;
  logic [CNT_W-1:0] wc_limit;

  // Crossing latency is taken off the count so the total stays in bound
  assign wc_limit = CNT_W'(WC_CYCLES - sec_pkg::WC_MARGIN);

  always_ff @(posedge CLK) begin
    req_meta <= wc_req_reg;
    req_s    <= req_meta;
    req_d    <= req_s;
  end

  always_comb begin
    wc_run_next   = wc_run_reg;
    wc_cnt_next   = wc_cnt_reg;
    done_tog_next = done_tog_reg;
    if (req_s != req_d) begin
      wc_run_next = 1'b1;
      wc_cnt_next = '0;
    end else if (wc_run_reg) begin
      wc_cnt_next = wc_cnt_reg + CNT_W'(1);
      if (wc_cnt_reg >= wc_limit) begin
        wc_run_next   = 1'b0;
        done_tog_next = ~done_tog_reg;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wc_run_reg   <= 1'b0;
      wc_cnt_reg   <= '0;
      done_tog_reg <= 1'b0;
    end else begin
      wc_run_reg   <= wc_run_next;
      wc_cnt_reg   <= wc_cnt_next;
      done_tog_reg <= done_tog_next;
    end
  end

  sequence s_ctrl_eval;
    st_reg == sec_pkg::SEC_CTRL && scl_fall && !start_det && !stop_det &&
      bit_reg == sec_pkg::BIT_ACK;
  endsequence
  sequence s_wdata_eval;
    st_reg == sec_pkg::SEC_WDATA && scl_fall && !start_det && !stop_det &&
      bit_reg == sec_pkg::BIT_ACK;
  endsequence
  sequence s_master_ack_slot;
    st_reg == sec_pkg::SEC_RDATA && scl_rise && !start_det && !stop_det &&
      bit_reg == sec_pkg::BIT_ACK;
  endsequence
  AST_NO_ACK_BUSY: assert property (@(posedge LINK_CLK) disable iff (link_rst)
    s_ctrl_eval and busy |=> !drv_reg && st_reg == sec_pkg::SEC_IDLE)
    else $error("control byte acknowledged during write cycle");
  AST_CS_MATCH: assert property (@(posedge LINK_CLK) disable iff (link_rst)
    s_ctrl_eval and (sh_reg[3:1] != cs_s) |=> !drv_reg ##1 !drv_reg)
    else $error("chip select mismatch acknowledged");
  AST_CODE_MATCH: assert property (@(posedge LINK_CLK) disable iff (link_rst)
    s_ctrl_eval and (sh_reg[7:4] != sec_pkg::CTRL_CODE) |=> st_reg == sec_pkg::SEC_IDLE)
    else $error("wrong control code accepted");
  AST_POLL_ACK: assert property (@(posedge LINK_CLK) disable iff (link_rst)
    s_ctrl_eval and ctrl_match and !busy |=> drv_reg && st_reg != sec_pkg::SEC_IDLE)
    else $error("idle device failed to acknowledge control byte");
  AST_PAGE_INC: assert property (@(posedge LINK_CLK) disable iff (link_rst)
    s_wdata_eval |=> ptr_reg[11:5] == $past(ptr_reg[11:5]) &&
      ptr_reg[4:0] == 5'($past(ptr_reg[4:0]) + 5'h01) && drv_reg)
    else $error("page write pointer increment wrong");
  AST_WP_DISCARD: assert property (@(posedge LINK_CLK) disable iff (link_rst)
    stop_det && wr_pend_reg && wp_s |=> !commit_reg && valid_reg == 32'h0000_0000)
    else $error("protected write was committed");
  AST_COMMIT_HOLDS: assert property (@(posedge LINK_CLK) disable iff (link_rst)
    $rose(commit_reg) |-> commit_reg[*8])
    else $error("commit burst cut short");
  AST_READ_WRAP: assert property (@(posedge LINK_CLK) disable iff (link_rst)
    s_master_ack_slot and ptr_reg == sec_pkg::TOP_WORD_ADDRESS |=> ptr_reg == 12'h000)
    else $error("read pointer did not wrap to zero");
  AST_NACK_RELEASE: assert property (@(posedge LINK_CLK) disable iff (link_rst)
    s_master_ack_slot and sda_s |=> !drv_reg && st_reg == sec_pkg::SEC_IDLE)
    else $error("data line not released after master nack");
  AST_READ_NEXT: assert property (@(posedge LINK_CLK) disable iff (link_rst)
    s_master_ack_slot |=> ptr_reg == 12'($past(ptr_reg) + 12'h001))
    else $error("pointer not advanced after read byte");
  AST_WC_BOUND: assert property (@(posedge CLK) disable iff (RST)
    wc_run_reg && wc_cnt_reg >= wc_limit && req_s == req_d |=>
      !wc_run_reg && done_tog_reg != $past(done_tog_reg))
    else $error("write cycle timer overran its bound");

endmodule : sec_eeprom_slave

`default_nettype wire

// ### dv/sec_master_model.sv
// Two-wire bus master model: drives SCL and an open-drain enable for SDA.
// Assumes the bench resolves SDA with a pull-up and calls one task at a time.
`timescale 1ns/1ps
`default_nettype none
module sec_master_model #(
  parameter int Q = 5
) (
  input  wire logic LINK_CLK,
  input  wire logic SDA,
  output var logic  SCL,
  output var logic  SDA_OE
);
  initial begin
    SCL = 1'b1;
    SDA_OE = 1'b0;
  end

  task automatic wt();
    repeat (Q) @(posedge LINK_CLK);
  endtask : wt

  // Also serves as repeated start when SCL is low
  task automatic start();
    @(posedge LINK_CLK);
    SDA_OE <= 1'b0;
    wt();
    SCL <= 1'b1;
    wt();
    SDA_OE <= 1'b1;
    wt();
    SCL <= 1'b0;
    wt();
  endtask : start

  task automatic stop();
    SDA_OE <= 1'b1;
    wt();
    SCL <= 1'b1;
    wt();
    SDA_OE <= 1'b0;
    wt();
  endtask : stop

  // Data changes only while SCL is low
  task automatic bit_xfer(input logic b, output logic r);
    SDA_OE <= !b;
    wt();
    SCL <= 1'b1;
    wt();
    r = SDA;
    wt();
    SCL <= 1'b0;
    wt();
  endtask : bit_xfer

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = !r;
  endtask : wbyte

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(!mack, r);
  endtask : rbyte
endmodule : sec_master_model
`default_nettype wire

// ### dv/serial_eeprom_command_slave_bench.sv
// Testbench of the serial EEPROM command slave: writes, polling, protection,
// chip select matching and the three kinds of read.
// Assumes sec_master_model and a shortened write-cycle timer.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_slave_bench;
  localparam int         WC = 1200;
  localparam logic [2:0] CS = 3'h5;
  logic        clk;
  logic        link_clk;
  logic        rst;
  logic        wp;
  logic [2:0]  cs_pins;
  logic        scl;
  logic        m_oe;
  logic        dev_o;
  logic        dev_oe;
  wire         sda;
  logic [7:0]  mem_exp [0:4095];
  logic [11:0] ptr_exp;
  int          fail_count;
  int          n_compared;
  int          cycles;

  // Pull-up on the open-drain wire
  assign sda = !(dev_oe | m_oe);

  sec_eeprom_slave #(.WC_CYCLES(WC)) u_dut (
    .CLK(clk), .RST(rst), .LINK_CLK(link_clk), .SCL(scl), .SDA_I(sda),
    .SDA_O(dev_o), .SDA_OE(dev_oe), .WP(wp), .CHIP_SELECT_BIT0(cs_pins[0]),
    .CHIP_SELECT_BIT1(cs_pins[1]), .CHIP_SELECT_BIT2(cs_pins[2]));

  sec_master_model #(.Q(5)) u_mst (.LINK_CLK(link_clk), .SDA(sda), .SCL(scl), .SDA_OE(m_oe));

  always #5 clk = ~clk;

  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      fail_count++;
      $display("wrong value at %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // Write control byte and word address; junk in the ignored upper nibble
  task automatic addr_cmd(input logic [11:0] a);
    logic ack;
    u_mst.start();
    u_mst.wbyte({4'ha, CS, 1'b0}, ack);
    chk1(ack, 1'b1);
    u_mst.wbyte({4'ha, a[11:8]}, ack);
    chk1(ack, 1'b1);
    u_mst.wbyte(a[7:0], ack);
    chk1(ack, 1'b1);
  endtask : addr_cmd

  task automatic wr(input logic [11:0] a, input int n, input logic [7:0] base);
    logic        ack;
    logic [11:0] p;
    addr_cmd(a);
    p = a;
    for (int i = 0; i < n; i++) begin
      u_mst.wbyte(base + 8'(i), ack);
      chk1(ack, 1'b1);
      if (wp === 1'b0) mem_exp[p] = base + 8'(i);
      p[4:0] = p[4:0] + 5'h1;
    end
    u_mst.stop();
    ptr_exp = p;
  endtask : wr

  task automatic poll(output int tries, output logic ok);
    ok = 1'b0;
    tries = 0;
    while (ok !== 1'b1 && tries < 8) begin
      u_mst.start();
      u_mst.wbyte({4'ha, CS, 1'b0}, ok);
      tries++;
    end
    u_mst.stop();
  endtask : poll

  task automatic wr_poll(input logic [11:0] a, input int n, input logic [7:0] base,
                         input logic busy);
    int   tries;
    logic ok;
    wr(a, n, base);
    poll(tries, ok);
    chk1(ok, 1'b1);
    chk1(tries > 1, busy);
  endtask : wr_poll

  // Reads n bytes from the pointer; master acks all but the last
  task automatic rd(input int n);
    logic       ack;
    logic [7:0] d;
    u_mst.start();
    u_mst.wbyte({4'ha, CS, 1'b1}, ack);
    chk1(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_mst.rbyte(i < n - 1, d);
      chk8(d, mem_exp[ptr_exp]);
      ptr_exp = ptr_exp + 12'h1;
    end
    chk1(dev_oe, 1'b0);
    chk1(dev_o, 1'b0);
    u_mst.stop();
  endtask : rd

  // Page overrun from near the top: wraps in page, newer bytes win
  task automatic s_page();
    wr_poll(12'h000, 1, 8'h3c, 1'b1);
    wr_poll(12'hffc, 33, 8'h10, 1'b1);
    addr_cmd(12'hfe0);
    ptr_exp = 12'hfe0;
    rd(32);
    rd(1);
  endtask : s_page

  // Byte write leaves the pointer one above; read then rolls over to zero
  task automatic s_byte();
    wr_poll(12'hffe, 1, 8'hc3, 1'b1);
    rd(2);
  endtask : s_byte

  task automatic s_protect();
    int   tries;
    logic ok;
    @(posedge clk);
    wp <= 1'b1;
    wr_poll(12'h000, 1, 8'h99, 1'b0);
    addr_cmd(12'h000);
    ptr_exp = 12'h000;
    rd(1);
    @(posedge clk);
    wp <= 1'b0;
    wr(12'h001, 1, 8'h77);
    @(posedge clk);
    wp <= 1'b1;
    poll(tries, ok);
    chk1(ok, 1'b1);
    chk1(tries > 1, 1'b1);
    addr_cmd(12'h001);
    ptr_exp = 12'h001;
    rd(1);
    @(posedge clk);
    wp <= 1'b0;
  endtask : s_protect

  // Every chip select pattern and single-bit errors in the control code
  task automatic s_select();
    logic ack;
    for (int k = 0; k < 8; k++) begin
      u_mst.start();
      u_mst.wbyte({4'ha, 3'(k), 1'b0}, ack);
      chk1(ack, 3'(k) == CS);
      u_mst.start();
      u_mst.wbyte({4'ha ^ (4'h1 << k[1:0]), CS, k[2]}, ack);
      chk1(ack, 1'b0);
      u_mst.stop();
    end
  endtask : s_select

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wp = 1'b0;
    cs_pins = CS;
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    ptr_exp = 12'h000;
    repeat (10) @(posedge clk);
    repeat (4) @(posedge link_clk);
    @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge link_clk);
    s_page();
    s_byte();
    s_protect();
    s_select();
    final_report();
  end
endmodule : serial_eeprom_command_slave_bench
`default_nettype wire
